// [shared/sensor_io_pkg.sv]
package sensor_io_pkg;

  // byte addresses of the command word (bits 14:8)
  localparam logic [6:0] ADDR_AUX_LO = 7'h30;
  localparam logic [6:0] ADDR_AUX_HI = 7'h31;
  localparam logic [6:0] ADDR_IO_LO = 7'h32;
  localparam logic [6:0] ADDR_IO_HI = 7'h33;
  localparam logic [6:0] ADDR_MISC_LO = 7'h34;
  localparam logic [6:0] ADDR_MISC_HI = 7'h35;
  localparam logic [6:0] ADDR_CMD_LO = 7'h3e;
  localparam logic [6:0] ADDR_CMD_HI = 7'h3f;

  // command word layout
  localparam int CMD_WRITE_BIT = 15;

  // misc_control fields
  localparam int MISC_DRDY_LINE = 0;
  localparam int MISC_DRDY_POL = 1;
  localparam int MISC_DRDY_EN = 2;
  localparam int MISC_ORIGIN = 6;
  localparam int MISC_BIAS = 7;
  localparam int MISC_STIM_POS = 8;
  localparam int MISC_STIM_NEG = 9;
  localparam int MISC_SELFTEST = 10;
  localparam int MISC_MEMTEST = 11;
  localparam logic [9:0] MISC_STORE_MASK = 10'h3c7;

  // command_trigger fields
  localparam int CMD_DAC_LATCH = 2;

  // io_line_control fields
  localparam int IO_DIR_LSB = 0;
  localparam int IO_LVL_LSB = 8;
  localparam int IO_EXT_CLK_LINE = 3;

  // values after reset
  localparam logic [15:0] IO_RESET = 16'h0000;
  localparam logic [15:0] MISC_RESET = 16'h0006;
  localparam logic [15:0] AUX_RESET = 16'h0000;

  // data-ready pulse timing
  localparam longint unsigned CLK_HZ = 25_000_000;
  localparam longint unsigned DRDY_MIN_US = 100;
  localparam longint unsigned DRDY_MAX_US = 200;
  localparam longint unsigned DRDY_MIN_CYC =
    (DRDY_MIN_US * CLK_HZ + 64'd999_999) / 64'd1_000_000;
  localparam longint unsigned DRDY_MAX_CYC =
    (DRDY_MAX_US * CLK_HZ) / 64'd1_000_000;
  localparam int DRDY_CNT_W = 13;
  localparam logic [12:0] DRDY_CYCLES = DRDY_MIN_CYC[12:0];

  typedef enum logic [0:0] {
    OP_IDLE = 1'b0,
    OP_BUSY = 1'b1
  } op_state_e;

endpackage

// [shared/op_if.sv]
`timescale 1ns/1ns
`default_nettype none
interface op_if #(parameter int W = 1);
  logic start;
  logic done;
  logic [W-1:0] fail;
  modport trig (output start, input done, input fail);
  modport engine (input start, output done, output fail);
endinterface
`default_nettype wire

// [hdl/op_trigger.sv]
`timescale 1ns/1ns
`default_nettype none
module op_trigger #(parameter int W = 1) (
  // clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // software trigger
  input wire logic arm,
  output logic busy,
  output logic [W-1:0] result_reg,
  // engine side
  op_if.trig op
);
  import sensor_io_pkg::*;

  op_state_e state_reg;
  logic start_reg;

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      state_reg <= OP_IDLE;
      start_reg <= 1'b0;
    end else begin
      start_reg <= arm && (state_reg == OP_IDLE);
      unique case (state_reg)
        OP_IDLE: if (arm) state_reg <= OP_BUSY;
        OP_BUSY: if (op.done && !start_reg) state_reg <= OP_IDLE;
      endcase
    end
  end

  // result kept until the next completion
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      result_reg <= '0;
    end else if (state_reg == OP_BUSY && op.done && !start_reg) begin
      result_reg <= op.fail;
    end
  end

  assign op.start = start_reg;
  assign busy = (state_reg == OP_BUSY);

  start_pulse_a: assert property (
    @(posedge clock) disable iff (sys_rst)
    (arm && state_reg == OP_IDLE) |=> start_reg ##1 !start_reg)
    else $error("start pulse missing after trigger");

endmodule // op_trigger
`default_nettype wire

// [hdl/sensor_io_ctrl.sv]
// How it works
// - io lines 1-2: data ready wins, then alarm, then general-purpose control
// - io_line_control bits 3:0 set line direction, one means output
// - bits 11:8 drive output lines; reads return pin state for inputs
// - line 4 input and zero increment select external sample edges
// - after reset data ready drives line 1 active high
// - data-ready pulse lasts between 100 and 200 microseconds
// - misc bit 2 enable, bit 1 polarity, bit 0 line select
// - memory-test bit starts flash check; result to flag, bit self-clears
// - self-test bit runs routine, posts flags, clears when done
// - misc bits 9 and 8 apply negative and positive stimulus while set
// - misc bit 7 bias correction, bit 6 origin alignment enable
// - aux converter register holds 12-bit code, upper bits unused
// - converter input changes only on latch command, both bytes together
// - every trigger bit returns to zero after its operation
`timescale 1ns/1ns
`default_nettype none
module sensor_io_ctrl (
  // clock and reset
  input wire logic clock,
  input wire logic sys_rst,
  // serial command words
  input wire logic cmd_valid,
  input wire logic [15:0] cmd_word,
  output logic [15:0] rd_word,
  // io lines
  input wire logic [3:0] io_in,
  output logic [3:0] io_out,
  output logic [3:0] io_oe,
  // alarm indicator
  input wire logic alarm_out_en,
  input wire logic alarm_polarity,
  input wire logic alarm_line_sel,
  input wire logic alarm_active,
  // sampling
  input wire logic [6:0] sample_incr,
  input wire logic internal_tick,
  output logic sample_tick,
  input wire logic outputs_written,
  // sensor controls
  output logic bias_comp_en,
  output logic origin_align_en,
  output logic stim_neg,
  output logic stim_pos,
  // converter
  output logic [11:0] dac_input,
  // memory test
  output logic memtest_start,
  input wire logic memtest_done,
  input wire logic memtest_fail,
  output logic flash_check_flag,
  // internal self-test
  output logic selftest_start,
  input wire logic selftest_done,
  input wire logic [5:0] selftest_fail,
  output logic [5:0] selftest_flags,
  output logic selftest_error
);
  import sensor_io_pkg::*;

  logic [15:0] io_reg;
  logic [9:0] misc_reg;
  logic [11:0] aux_reg;
  logic [DRDY_CNT_W-1:0] drdy_cnt_reg;
  logic line4_prev_reg;
  logic mem_busy, st_busy;
  logic [15:0] misc_view, io_view;
  logic [6:0] addr;
  logic is_write, wr, rd, drdy_active, ext_mode, ext_edge;

  op_if #(.W(1)) mem_op ();
  op_if #(.W(6)) st_op ();

  assign addr = cmd_word[14:8];
  assign is_write = cmd_word[CMD_WRITE_BIT];
  assign wr = cmd_valid && is_write;
  assign rd = cmd_valid && !is_write;

  // io_line_control storage
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      io_reg <= IO_RESET;
    end else if (wr && addr == ADDR_IO_LO) begin
      io_reg[3:0] <= cmd_word[3:0];
    end else if (wr && addr == ADDR_IO_HI) begin
      io_reg[11:8] <= cmd_word[3:0];
    end
  end

  // misc_control storage; bits 11:10 live in the trigger units
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      misc_reg <= MISC_RESET[9:0];
    end else if (wr && addr == ADDR_MISC_LO) begin
      misc_reg[7:0] <= cmd_word[7:0] & MISC_STORE_MASK[7:0];
    end else if (wr && addr == ADDR_MISC_HI) begin
      misc_reg[9:8] <= cmd_word[1:0];
    end
  end

  // aux converter: staged value, then latched both bytes at once
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      aux_reg <= AUX_RESET[11:0];
    end else if (wr && addr == ADDR_AUX_LO) begin
      aux_reg[7:0] <= cmd_word[7:0];
    end else if (wr && addr == ADDR_AUX_HI) begin
      aux_reg[11:8] <= cmd_word[3:0];
    end
  end

  // latch completes in one cycle, so the trigger bit never reads back set
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      dac_input <= AUX_RESET[11:0];
    end else if (wr && addr == ADDR_CMD_LO && cmd_word[CMD_DAC_LATCH]) begin
      dac_input <= aux_reg;
    end
  end

  op_trigger #(.W(1)) mem_trig (
    .clock(clock),
    .sys_rst(sys_rst),
    .arm(wr && addr == ADDR_MISC_HI && cmd_word[MISC_MEMTEST - 8]),
    .busy(mem_busy),
    .result_reg(flash_check_flag),
    .op(mem_op)
  );

  op_trigger #(.W(6)) st_trig (
    .clock(clock),
    .sys_rst(sys_rst),
    .arm(wr && addr == ADDR_MISC_HI && cmd_word[MISC_SELFTEST - 8]),
    .busy(st_busy),
    .result_reg(selftest_flags),
    .op(st_op)
  );

  assign memtest_start = mem_op.start;
  assign mem_op.done = memtest_done;
  assign mem_op.fail = memtest_fail;
  assign selftest_start = st_op.start;
  assign st_op.done = selftest_done;
  assign st_op.fail = selftest_fail;
  assign selftest_error = |selftest_flags;

  // trigger bits read as busy, so they drop on completion
  assign misc_view = {4'h0, mem_busy, st_busy, misc_reg};
  always_comb begin
    io_view = {4'h0, 4'h0, 4'h0, io_reg[3:0]};
    for (int i = 0; i < 4; i++) begin
      io_view[IO_LVL_LSB + i] = io_reg[IO_DIR_LSB + i] ?
        io_reg[IO_LVL_LSB + i] : io_in[i];
    end
  end

  // read answer held for the next transfer
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      rd_word <= 16'h0000;
    end else if (rd) begin
      unique case (addr)
        ADDR_IO_LO, ADDR_IO_HI: rd_word <= io_view;
        ADDR_MISC_LO, ADDR_MISC_HI: rd_word <= misc_view;
        ADDR_AUX_LO, ADDR_AUX_HI: rd_word <= {4'h0, aux_reg};
        default: rd_word <= 16'h0000;
      endcase
    end
  end

  assign stim_neg = misc_reg[MISC_STIM_NEG];
  assign stim_pos = misc_reg[MISC_STIM_POS];
  assign bias_comp_en = misc_reg[MISC_BIAS];
  assign origin_align_en = misc_reg[MISC_ORIGIN];

  // external sample clock on line 4; follows the pin through reset so a
  // line held high at release gives no false edge
  always_ff @(posedge clock) begin
    line4_prev_reg <= io_in[IO_EXT_CLK_LINE];
  end
  assign ext_mode = !io_reg[IO_EXT_CLK_LINE] && sample_incr == 7'h00;
  assign ext_edge = io_in[IO_EXT_CLK_LINE] && !line4_prev_reg;
  assign sample_tick = ext_mode ? ext_edge : internal_tick;

  // fixed-length pulse sits at the short end of the allowed window
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      drdy_cnt_reg <= '0;
    end else if (drdy_active) begin
      drdy_cnt_reg <= drdy_cnt_reg - 13'h0001;
    end else if (outputs_written && misc_reg[MISC_DRDY_EN]) begin
      drdy_cnt_reg <= DRDY_CYCLES;
    end
  end
  assign drdy_active = drdy_cnt_reg != '0;

  // line ownership: data ready, then alarm, then general-purpose
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      io_oe[i] = io_reg[IO_DIR_LSB + i];
      io_out[i] = io_reg[IO_LVL_LSB + i];
      if (i < 2 && alarm_out_en && alarm_line_sel == i[0]) begin
        io_oe[i] = 1'b1;
        io_out[i] = alarm_active ^ !alarm_polarity;
      end
      if (i < 2 && misc_reg[MISC_DRDY_EN] &&
          misc_reg[MISC_DRDY_LINE] == i[0]) begin
        io_oe[i] = 1'b1;
        io_out[i] = drdy_active ^ !misc_reg[MISC_DRDY_POL];
      end
    end
  end

  // assertion helpers
  logic [DRDY_CNT_W-1:0] drdy_len_reg;
  always_ff @(posedge clock) begin
    if (sys_rst) drdy_len_reg <= '0;
    else if (drdy_active) drdy_len_reg <= drdy_len_reg + 13'h0001;
    else drdy_len_reg <= '0;
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  drdy_width_a: assert property (
    $fell(drdy_active) |-> drdy_len_reg == DRDY_CYCLES &&
      drdy_len_reg >= DRDY_MIN_CYC[12:0] &&
      drdy_len_reg <= DRDY_MAX_CYC[12:0])
    else $error("data-ready pulse width out of range");
  drdy_start_a: assert property (
    outputs_written && misc_reg[MISC_DRDY_EN] && !drdy_active
      |=> drdy_active)
    else $error("no data-ready pulse after output update");
  drdy_pin_a: assert property (
    misc_reg[MISC_DRDY_EN] && drdy_active |-> io_oe[misc_reg[0]] &&
      io_out[misc_reg[0]] == misc_reg[MISC_DRDY_POL])
    else $error("data-ready level wrong on selected line");
  reset_line_a: assert property (
    $past(sys_rst) |-> io_oe[0] && !io_oe[1] && !io_out[0])
    else $error("line 1 not idle data-ready output after reset");
  alarm_owner_a: assert property (
    alarm_out_en && !(misc_reg[MISC_DRDY_EN] &&
      misc_reg[MISC_DRDY_LINE] == alarm_line_sel) |->
      io_oe[alarm_line_sel] &&
      io_out[alarm_line_sel] == (alarm_active ^ !alarm_polarity))
    else $error("alarm not driving its line");
  io_dir_a: assert property (
    wr && addr == ADDR_IO_LO |=> io_oe[3:2] == $past(cmd_word[3:2]))
    else $error("line direction not applied");
  io_read_a: assert property (
    rd && addr == ADDR_IO_LO && !io_reg[0] |=> rd_word[8] == $past(io_in[0]))
    else $error("input line state not returned");
  ext_clock_a: assert property (
    ext_mode && io_in[3] && !$past(io_in[3]) |-> sample_tick)
    else $error("external edge did not sample");
  dac_latch_a: assert property (
    wr && addr == ADDR_AUX_LO |=> dac_input == $past(dac_input))
    else $error("converter changed without latch");
  memtest_clear_a: assert property (
    misc_view[MISC_MEMTEST] && memtest_done && !memtest_start
      |=> !misc_view[MISC_MEMTEST] && flash_check_flag == $past(memtest_fail))
    else $error("memory test did not finish cleanly");
  selftest_clear_a: assert property (
    misc_view[MISC_SELFTEST] && selftest_done && !selftest_start
      |=> !misc_view[MISC_SELFTEST] && selftest_flags == $past(selftest_fail))
    else $error("self-test did not finish cleanly");
  stim_hold_a: assert property (
    stim_neg && !(wr && addr == ADDR_MISC_HI) |=> stim_neg)
    else $error("stimulus dropped without host clear");
  aux_upper_a: assert property (
    rd && addr == ADDR_AUX_HI |=> rd_word[15:12] == 4'h0)
    else $error("unused converter bits not zero");

  drdy_seen_c: cover property ($fell(drdy_active));
  ext_sample_c: cover property (ext_mode && sample_tick);
  memtest_run_c: cover property (memtest_start ##[1:20] memtest_done);
  dac_move_c: cover property ($changed(dac_input));

endmodule // sensor_io_ctrl
`default_nettype wire

// [verif/host_model.sv]
`timescale 1ns/1ns
`default_nettype none
module host_model #(
  parameter int SETTLE = 8
) (
  // clock
  input wire logic clock,
  // command port
  output logic cmd_valid,
  output logic [15:0] cmd_word,
  input wire logic [15:0] rd_word
);
  import sensor_io_pkg::*;

  initial begin
    cmd_valid = 1'b0;
    cmd_word = 16'h0000;
  end

  // released word is inverted so stale data never looks valid
  task automatic send(input logic [15:0] w);
    @(negedge clock);
    cmd_valid = 1'b1;
    cmd_word = w;
    @(negedge clock);
    cmd_valid = 1'b0;
    cmd_word = ~w;
  endtask

  task automatic read(input logic [6:0] a, output logic [15:0] r);
    send({1'b0, a, 8'h00});
    r = rd_word;
  endtask

  task automatic wr16(input logic [6:0] lo, input logic [15:0] d);
    send({1'b1, lo + 7'h01, d[15:8]});
    send({1'b1, lo, d[7:0]});
  endtask

  // settle wait cut far below the real figure to keep runs short
  task automatic stim(input logic [1:0] s);
    send({1'b1, ADDR_MISC_HI, 6'h00, s});
    repeat (SETTLE) @(negedge clock);
  endtask
endmodule // host_model
`default_nettype wire

// [verif/sensor_io_and_selftest_ctrl_tb.sv]
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin num_errors++; \
  $display("[ERR] %0t got %h exp %h", $time, (a), (e)); end end
module sensor_io_and_selftest_ctrl_tb;
  import sensor_io_pkg::*;
  typedef struct packed {
    logic [15:0] io;
    logic [15:0] misc;
    logic [3:0] alm;
    logic [3:0] oe;
    logic [3:0] out;
  } row_s;
  logic clock, sys_rst, cmd_valid;
  logic [15:0] cmd_word, rd_word, r;
  logic [3:0] io_in, io_out, io_oe, ext, pin;
  logic [3:0] ctl;
  logic alarm_out_en, alarm_polarity, alarm_line_sel, alarm_active;
  logic [6:0] sample_incr;
  logic internal_tick, sample_tick, outputs_written;
  logic bias_comp_en, origin_align_en, stim_neg, stim_pos;
  logic [11:0] dac_input;
  logic memtest_start, memtest_done, memtest_fail, flash_check_flag;
  logic selftest_start, selftest_done, selftest_error;
  logic [5:0] selftest_fail, selftest_flags;
  int num_errors = 0;
  int checked = 0;
  int n;
  row_s rows [6];

  // pin level resolves device drive against the outside world
  assign io_in = (io_oe & io_out) | (~io_oe & ext);
  assign ctl = {bias_comp_en, origin_align_en, stim_neg, stim_pos};

  sensor_io_ctrl u_dut (
    .clock(clock), .sys_rst(sys_rst),
    .cmd_valid(cmd_valid), .cmd_word(cmd_word), .rd_word(rd_word),
    .io_in(io_in), .io_out(io_out), .io_oe(io_oe),
    .alarm_out_en(alarm_out_en), .alarm_polarity(alarm_polarity),
    .alarm_line_sel(alarm_line_sel), .alarm_active(alarm_active),
    .sample_incr(sample_incr), .internal_tick(internal_tick),
    .sample_tick(sample_tick), .outputs_written(outputs_written),
    .bias_comp_en(bias_comp_en), .origin_align_en(origin_align_en),
    .stim_neg(stim_neg), .stim_pos(stim_pos), .dac_input(dac_input),
    .memtest_start(memtest_start), .memtest_done(memtest_done),
    .memtest_fail(memtest_fail), .flash_check_flag(flash_check_flag),
    .selftest_start(selftest_start), .selftest_done(selftest_done),
    .selftest_fail(selftest_fail), .selftest_flags(selftest_flags),
    .selftest_error(selftest_error));
  host_model u_host (.clock(clock), .cmd_valid(cmd_valid),
    .cmd_word(cmd_word), .rd_word(rd_word));

  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end

  task automatic give_verdict();
    $display("errors %0d checks %0d", num_errors, checked);
    if (num_errors == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic tick(input logic e3, input logic it, input logic x);
    @(negedge clock);
    ext[3] = e3;
    internal_tick = it;
    #1;
    `CHK(sample_tick, x)
  endtask

  task automatic run_op(input logic [15:0] w, input int b);
    logic [15:0] q;
    u_host.send(w);
    `CHK(b == 11 ? memtest_start : selftest_start, 1'b1)
    u_host.read(ADDR_MISC_LO, q);
    `CHK(q[b], 1'b1)
    // second trigger while busy must not restart the engine
    u_host.send(w);
    `CHK(memtest_start | selftest_start, 1'b0)
    @(negedge clock);
    memtest_done = (b == 11);
    memtest_fail = 1'b1;
    selftest_done = (b == 10);
    selftest_fail = 6'h2a;
    @(negedge clock);
    memtest_done = 1'b0;
    selftest_done = 1'b0;
    u_host.read(ADDR_MISC_LO, q);
    `CHK(q[b], 1'b0)
  endtask

  initial begin
    #2_000_000;
    num_errors++;
    give_verdict();
  end

  initial begin
    sys_rst = 1'b1;
    ext = 4'h0;
    {alarm_out_en, alarm_polarity, alarm_line_sel, alarm_active} = 4'h0;
    sample_incr = 7'h01;
    internal_tick = 1'b0;
    outputs_written = 1'b0;
    memtest_done = 1'b0;
    memtest_fail = 1'b0;
    selftest_done = 1'b0;
    selftest_fail = 6'h00;
    rows = '{
      '{16'h080c, 16'h0006, 4'h0, 4'b1101, 4'b1000},
      '{16'h0f0f, 16'h0000, 4'h0, 4'b1111, 4'b1111},
      '{16'h0003, 16'h0000, 4'hf, 4'b0011, 4'b0010},
      '{16'h0103, 16'h0005, 4'he, 4'b0011, 4'b0011},
      '{16'h0000, 16'h0004, 4'h0, 4'b0001, 4'b0001},
      '{16'h0000, 16'hf3fe, 4'h0, 4'b0001, 4'b0000}};
    repeat (4) @(negedge clock);
    sys_rst = 1'b0;
    `CHK(io_oe, 4'b0001)
    `CHK(io_out, 4'b0000)
    `CHK(dac_input, 12'h000)
    u_host.read(ADDR_MISC_HI, r);
    `CHK(r, 16'h0006)
    u_host.read(ADDR_IO_LO, r);
    `CHK(r, 16'h0000)
    u_host.read(ADDR_AUX_LO, r);
    `CHK(r, 16'h0000)
    ext = 4'b0110;
    foreach (rows[i]) begin
      {alarm_out_en, alarm_polarity, alarm_line_sel, alarm_active} =
        rows[i].alm;
      u_host.wr16(ADDR_IO_LO, rows[i].io);
      u_host.wr16(ADDR_MISC_LO, rows[i].misc);
      `CHK(io_oe, rows[i].oe)
      `CHK(io_out, rows[i].out)
      r = {4'h0, rows[i].misc[7:6], rows[i].misc[9:8]};
      `CHK(ctl, r[3:0])
      pin = (rows[i].oe & rows[i].out) | (~rows[i].oe & ext);
      // output lines read back the stored level even when another owner
      // drives the pin; input lines read the pin
      pin = (rows[i].io[3:0] & rows[i].io[11:8]) | (~rows[i].io[3:0] & pin);
      u_host.read(ADDR_IO_HI, r);
      `CHK(r, {4'h0, pin, 4'h0, rows[i].io[3:0]})
      u_host.read(ADDR_MISC_LO, r);
      `CHK(r, rows[i].misc & 16'h03c7)
    end
    {alarm_out_en, alarm_polarity, alarm_line_sel, alarm_active} = 4'h0;
    u_host.wr16(ADDR_MISC_LO, 16'h0006);
    @(negedge clock);
    outputs_written = 1'b1;
    n = 0;
    // a second sample mid-pulse must not stretch it
    repeat (6000) begin
      @(negedge clock);
      outputs_written = (n == 100);
      if (io_out[0] === 1'b1) n++;
    end
    `CHK(n >= 2500 && n <= 5000, 1'b1)
    u_host.wr16(ADDR_MISC_LO, 16'h0002);
    outputs_written = 1'b1;
    @(negedge clock);
    outputs_written = 1'b0;
    `CHK(io_oe[0], 1'b0)
    for (int s = 2; s >= 0; s--) begin
      u_host.stim(2'(s));
      `CHK({stim_neg, stim_pos}, 2'(s))
    end
    u_host.wr16(ADDR_IO_LO, 16'h0000);
    sample_incr = 7'h00;
    tick(1'b0, 1'b1, 1'b0);
    tick(1'b1, 1'b0, 1'b1);
    tick(1'b1, 1'b0, 1'b0);
    sample_incr = 7'h01;
    tick(1'b0, 1'b0, 1'b0);
    tick(1'b1, 1'b0, 1'b0);
    tick(1'b1, 1'b1, 1'b1);
    @(negedge clock);
    internal_tick = 1'b0;
    u_host.send(16'hb0d9);
    u_host.send(16'hb104);
    `CHK(dac_input, 12'h000)
    u_host.read(ADDR_AUX_HI, r);
    `CHK(r, 16'h04d9)
    u_host.send(16'hbe04);
    `CHK(dac_input, 12'h4d9)
    u_host.read(ADDR_CMD_LO, r);
    `CHK(r[2], 1'b0)
    u_host.read(7'h10, r);
    `CHK(r, 16'h0000)
    run_op(16'hb508, 11);
    run_op(16'hb504, 10);
    `CHK(flash_check_flag, 1'b1)
    `CHK(selftest_flags, 6'h2a)
    `CHK(selftest_error, 1'b1)
    // reset in mid-run restores the factory line setup and clears results
    @(negedge clock);
    sys_rst = 1'b1;
    repeat (2) @(negedge clock);
    sys_rst = 1'b0;
    `CHK({io_oe, io_out}, 8'h10)
    `CHK({flash_check_flag, selftest_flags}, 7'h00)
    `CHK(dac_input, 12'h000)
    `CHK(rd_word, 16'h0000)
    u_host.read(ADDR_MISC_HI, r);
    `CHK(r, 16'h0006)
    give_verdict();
  end
endmodule // sensor_io_and_selftest_ctrl_tb
`default_nettype wire
